// ### core/dec_pkg.sv
// How it works
// - 01 dst src, no field 110, copies reg to reg in 4 cycles.
// - 01110 src stores a register to memory at HL, 7 cycles.
// - 01 dst 110 loads a register from memory at HL, 7 cycles.
// - 00 pp 0001 with pair BC, DE or HL loads immediate word, 10 cycles.
// - 00110001 loads an immediate word into the stack pointer, 10 cycles.
// - 11101011 swaps DE with HL, 4 cycles.
// - 11 pp 0101 with pair BC, DE or HL pushes that pair, 12 cycles.
// - 11110101 pushes accumulator and flags, 12 cycles.
// - 11000001 and 11010001 pop into BC or DE, 10 cycles.
// - 11100001 pops into HL, 10 cycles.
// - 11110001 pops into accumulator and flags, 10 cycles.
package dec_pkg;

  // ---------------------------------------------------------------
  // opcode field positions
  // ---------------------------------------------------------------
  localparam int GRP_MSB  = 7;
  localparam int GRP_LSB  = 6;
  localparam int DST_MSB  = 5;
  localparam int DST_LSB  = 3;
  localparam int SRC_MSB  = 2;
  localparam int SRC_LSB  = 0;
  localparam int PAIR_MSB = 5;
  localparam int PAIR_LSB = 4;
  localparam int LOW_MSB  = 3;
  localparam int LOW_LSB  = 0;

  // ---------------------------------------------------------------
  // field codes
  // ---------------------------------------------------------------
  localparam logic [1:0] GRP_LOAD  = 2'h0;
  localparam logic [1:0] GRP_MOVE  = 2'h1;
  localparam logic [1:0] GRP_STACK = 2'h3;
  localparam logic [2:0] REG_B     = 3'h0;
  localparam logic [2:0] REG_C     = 3'h1;
  localparam logic [2:0] REG_D     = 3'h2;
  localparam logic [2:0] REG_E     = 3'h3;
  localparam logic [2:0] REG_H     = 3'h4;
  localparam logic [2:0] REG_L     = 3'h5;
  localparam logic [2:0] REG_M     = 3'h6;
  localparam logic [2:0] REG_A     = 3'h7;
  localparam logic [1:0] PAIR_BC   = 2'h0;
  localparam logic [1:0] PAIR_DE   = 2'h1;
  localparam logic [1:0] PAIR_HL   = 2'h2;
  localparam logic [1:0] PAIR_TOP  = 2'h3;
  localparam logic [3:0] LOW_PAIR1 = 4'h1;
  localparam logic [3:0] LOW_PUSH  = 4'h5;
  localparam logic [7:0] OPC_SWAP  = 8'heb;

  // ---------------------------------------------------------------
  // clock cycle counts
  // ---------------------------------------------------------------
  localparam int         CYC_W    = 5;
  localparam logic [4:0] CYC_COPY = 5'h04;
  localparam logic [4:0] CYC_MEM  = 5'h07;
  localparam logic [4:0] CYC_IMM  = 5'h0a;
  localparam logic [4:0] CYC_SWAP = 5'h04;
  localparam logic [4:0] CYC_PUSH = 5'h0c;
  localparam logic [4:0] CYC_POP  = 5'h0a;
  localparam logic [4:0] CNT_LAST = 5'h01;

  typedef enum logic [3:0] {
    OP_NONE, OP_COPY, OP_STORE_M, OP_LOAD_M, OP_LOAD_PAIR_IMM,
    OP_LOAD_SP_IMM, OP_SWAP, OP_PUSH_PAIR, OP_PUSH_AF, OP_POP_PAIR,
    OP_POP_AF
  } op_kind_t;

endpackage

// ### core/dec_if.sv
`timescale 1ns/1ps
interface dec_if;
  logic [7:0]       opcode;
  dec_pkg::op_kind_t kind;
  logic [2:0]       dst;
  logic [2:0]       src;
  logic [1:0]       pair;
  logic [4:0]       cycles;
  logic             hit;
  modport producer (input opcode, output kind, dst, src, pair, cycles, hit);
  modport consumer (output opcode, input kind, dst, src, pair, cycles, hit);
endinterface

// ### core/field_decode.sv
`timescale 1ns/1ps
module field_decode (
  // decoded opcode
  dec_if.producer d
);
  logic [1:0] grp;
  logic [3:0] low;

  assign grp = d.opcode[dec_pkg::GRP_MSB:dec_pkg::GRP_LSB];
  assign low = d.opcode[dec_pkg::LOW_MSB:dec_pkg::LOW_LSB];

  // ---------------------------------------------------------------
  // classify
  // ---------------------------------------------------------------
  always_comb begin
    d.dst    = d.opcode[dec_pkg::DST_MSB:dec_pkg::DST_LSB];
    d.src    = d.opcode[dec_pkg::SRC_MSB:dec_pkg::SRC_LSB];
    d.pair   = d.opcode[dec_pkg::PAIR_MSB:dec_pkg::PAIR_LSB];
    d.kind   = dec_pkg::OP_NONE;
    d.cycles = '0;
    if (grp == dec_pkg::GRP_MOVE) begin
      if (d.dst == dec_pkg::REG_M && d.src == dec_pkg::REG_M) begin
        d.kind = dec_pkg::OP_NONE;
      end else if (d.dst == dec_pkg::REG_M) begin
        d.kind   = dec_pkg::OP_STORE_M;
        d.cycles = dec_pkg::CYC_MEM;
      end else if (d.src == dec_pkg::REG_M) begin
        d.kind   = dec_pkg::OP_LOAD_M;
        d.cycles = dec_pkg::CYC_MEM;
      end else begin
        d.kind   = dec_pkg::OP_COPY;
        d.cycles = dec_pkg::CYC_COPY;
      end
    end else if (grp == dec_pkg::GRP_LOAD && low == dec_pkg::LOW_PAIR1) begin
      d.cycles = dec_pkg::CYC_IMM;
      if (d.pair == dec_pkg::PAIR_TOP) begin
        d.kind = dec_pkg::OP_LOAD_SP_IMM;
      end else begin
        d.kind = dec_pkg::OP_LOAD_PAIR_IMM;
      end
    end else if (d.opcode == dec_pkg::OPC_SWAP) begin
      d.kind   = dec_pkg::OP_SWAP;
      d.cycles = dec_pkg::CYC_SWAP;
    end else if (grp == dec_pkg::GRP_STACK && low == dec_pkg::LOW_PUSH) begin
      d.cycles = dec_pkg::CYC_PUSH;
      if (d.pair == dec_pkg::PAIR_TOP) begin
        d.kind = dec_pkg::OP_PUSH_AF;
      end else begin
        d.kind = dec_pkg::OP_PUSH_PAIR;
      end
    end else if (grp == dec_pkg::GRP_STACK && low == dec_pkg::LOW_PAIR1) begin
      d.cycles = dec_pkg::CYC_POP;
      if (d.pair == dec_pkg::PAIR_TOP) begin
        d.kind = dec_pkg::OP_POP_AF;
      end else begin
        d.kind = dec_pkg::OP_POP_PAIR;
      end
    end
    d.hit = (d.kind != dec_pkg::OP_NONE);
  end

endmodule

// ### core/cpu8_move_stack_decoder.sv
`timescale 1ns/1ps
module cpu8_move_stack_decoder (
  // clock and reset
  input  wire  logic              clk,
  input  wire  logic              sys_rst,
  // opcode request
  input  wire  logic              opcode_valid,
  input  wire  logic [7:0]        opcode,
  output logic                    req_ready,
  // decoded operation
  output logic                    op_valid,
  output dec_pkg::op_kind_t       op_kind,
  output logic [2:0]              dest_reg_field,
  output logic [2:0]              src_reg_field,
  output logic [1:0]              pair_sel,
  output logic [4:0]              op_cycles,
  output logic                    op_done,
  // opcodes for other decode paths
  output logic                    pass_valid,
  output logic [7:0]              pass_opcode
);

  typedef enum logic {ST_IDLE, ST_BUSY} st_t;

  typedef struct packed {
    st_t               st;
    logic [4:0]        cnt;
    logic              ready;
    logic              op_valid;
    dec_pkg::op_kind_t kind;
    logic [2:0]        dst;
    logic [2:0]        src;
    logic [1:0]        pair;
    logic [4:0]        cycles;
    logic              done;
    logic              pass_valid;
    logic [7:0]        pass_opcode;
  } state_t;

  state_t q;
  state_t d;
  logic   accept;

  dec_if dif ();

  field_decode u_dec (
    .d (dif)
  );

  assign dif.opcode = opcode;
  assign accept     = opcode_valid && q.ready;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d            = q;
    d.op_valid   = 1'b0;
    d.done       = 1'b0;
    d.pass_valid = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (accept && dif.hit) begin
          d.op_valid = 1'b1;
          d.kind     = dif.kind;
          d.dst      = dif.dst;
          d.src      = dif.src;
          d.pair     = dif.pair;
          d.cycles   = dif.cycles;
          d.cnt      = dif.cycles - dec_pkg::CNT_LAST;
          d.ready    = 1'b0;
          d.st       = ST_BUSY;
        end else if (accept) begin
          d.pass_valid  = 1'b1;
          d.pass_opcode = opcode;
        end
      end
      ST_BUSY: begin
        if (q.cnt == dec_pkg::CNT_LAST) begin
          d.done  = 1'b1;
          d.ready = 1'b1;
          d.st    = ST_IDLE;
        end else begin
          d.cnt = q.cnt - dec_pkg::CNT_LAST;
        end
      end
      default: begin
        d.st    = ST_IDLE;
        d.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q       <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign req_ready      = q.ready;
  assign op_valid       = q.op_valid;
  assign op_kind        = q.kind;
  assign dest_reg_field = q.dst;
  assign src_reg_field  = q.src;
  assign pair_sel       = q.pair;
  assign op_cycles      = q.cycles;
  assign op_done        = q.done;
  assign pass_valid     = q.pass_valid;
  assign pass_opcode    = q.pass_opcode;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [1:0] f_grp;
  logic [2:0] f_dst;
  logic [2:0] f_src;
  assign f_grp = opcode[7:6];
  assign f_dst = opcode[5:3];
  assign f_src = opcode[2:0];

  sequence s_wait4;
    !req_ready [*3] ##1 req_ready && op_done;
  endsequence

  sequence s_wait12;
    !req_ready [*8] ##1 !req_ready [*3] ##1 req_ready && op_done;
  endsequence

  property p_copy;
    accept && f_grp == 2'h1 && f_dst != 3'h6 && f_src != 3'h6 |=>
      op_valid && op_kind == dec_pkg::OP_COPY && op_cycles == 5'h04
      ##0 s_wait4;
  endproperty
  a_copy: assert property (p_copy)
    else $error("copy not decoded as 4 cycles");

  property p_store;
    accept && opcode[7:3] == 5'h0e && f_src != 3'h6 |=>
      op_kind == dec_pkg::OP_STORE_M && op_cycles == 5'h07 &&
      src_reg_field == $past(f_src);
  endproperty
  a_store: assert property (p_store)
    else $error("store to memory misdecoded");

  property p_load;
    accept && f_grp == 2'h1 && f_src == 3'h6 && f_dst != 3'h6 |=>
      op_kind == dec_pkg::OP_LOAD_M && op_cycles == 5'h07 &&
      dest_reg_field == $past(f_dst);
  endproperty
  a_load: assert property (p_load)
    else $error("load from memory misdecoded");

  property p_pair_imm;
    accept && (opcode == 8'h01 || opcode == 8'h11 || opcode == 8'h21) |=>
      op_kind == dec_pkg::OP_LOAD_PAIR_IMM && op_cycles == 5'h0a &&
      pair_sel == $past(opcode[5:4]);
  endproperty
  a_pair_imm: assert property (p_pair_imm)
    else $error("pair immediate load misdecoded");

  property p_sp_imm;
    accept && opcode == 8'h31 |=>
      op_kind == dec_pkg::OP_LOAD_SP_IMM && op_cycles == 5'h0a;
  endproperty
  a_sp_imm: assert property (p_sp_imm)
    else $error("stack pointer load misdecoded");

  property p_swap;
    accept && opcode == 8'heb |=>
      op_kind == dec_pkg::OP_SWAP && op_cycles == 5'h04 ##0 s_wait4;
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap misdecoded");

  property p_push;
    accept && (opcode == 8'hc5 || opcode == 8'hd5 || opcode == 8'he5) |=>
      op_kind == dec_pkg::OP_PUSH_PAIR && op_cycles == 5'h0c ##0 s_wait12;
  endproperty
  a_push: assert property (p_push)
    else $error("pair push misdecoded");

  property p_push_af;
    accept && opcode == 8'hf5 |=>
      op_kind == dec_pkg::OP_PUSH_AF && op_cycles == 5'h0c;
  endproperty
  a_push_af: assert property (p_push_af)
    else $error("accumulator push misdecoded");

  property p_pop;
    accept && (opcode == 8'hc1 || opcode == 8'hd1) |=>
      op_kind == dec_pkg::OP_POP_PAIR && op_cycles == 5'h0a;
  endproperty
  a_pop: assert property (p_pop)
    else $error("pair pop misdecoded");

  property p_pop_hl;
    accept && opcode == 8'he1 |=>
      op_kind == dec_pkg::OP_POP_PAIR && pair_sel == 2'h2 &&
      op_cycles == 5'h0a;
  endproperty
  a_pop_hl: assert property (p_pop_hl)
    else $error("hl pop misdecoded");

  property p_pop_af;
    accept && opcode == 8'hf1 |=>
      op_kind == dec_pkg::OP_POP_AF && op_cycles == 5'h0a;
  endproperty
  a_pop_af: assert property (p_pop_af)
    else $error("accumulator pop misdecoded");

  property p_fields;
    op_valid && op_kind == dec_pkg::OP_COPY |->
      dest_reg_field != 3'h6 && src_reg_field != 3'h6;
  endproperty
  a_fields: assert property (p_fields)
    else $error("memory code used as a register");

  property p_pass;
    accept && !dif.hit |=>
      pass_valid && !op_valid && req_ready &&
      pass_opcode == $past(opcode);
  endproperty
  a_pass: assert property (p_pass)
    else $error("foreign opcode not passed on");

endmodule

// ### tb/exec_req_model.sv
`timescale 1ns/1ps
module exec_req_model (
  // clock
  input  wire logic       clk,
  // request side
  input  wire logic       req_ready,
  output logic            opcode_valid,
  output logic [7:0]      opcode
);
  initial begin
    opcode_valid = 1'b0;
    opcode       = 8'h00;
  end

  // holds the request until an edge that sees req_ready high
  task automatic send(input logic [7:0] op, input bit keep);
    int n;
    n = 0;
    opcode_valid = 1'b1;
    opcode       = op;
    while (req_ready !== 1'b1 && n < 64) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    if (!keep) begin
      opcode_valid = 1'b0;
      opcode       = ~op;
    end
  endtask

  // changes the byte of a request still held high
  task automatic retarget(input logic [7:0] op);
    opcode = op;
  endtask
endmodule

// ### tb/cpu8_move_stack_decoder_tb_top.sv
`timescale 1ns/1ps
module cpu8_move_stack_decoder_tb_top;
  logic              clk;
  logic              sys_rst;
  logic              opcode_valid;
  logic [7:0]        opcode;
  logic              req_ready;
  logic              op_valid;
  dec_pkg::op_kind_t op_kind;
  logic [2:0]        dest_reg_field;
  logic [2:0]        src_reg_field;
  logic [1:0]        pair_sel;
  logic [4:0]        op_cycles;
  logic              op_done;
  logic              pass_valid;
  logic [7:0]        pass_opcode;
  int                miscompares;
  int                samples_checked;
  int                cyc = 0;

  cpu8_move_stack_decoder dut_u (
    .clk(clk), .sys_rst(sys_rst), .opcode_valid(opcode_valid),
    .opcode(opcode), .req_ready(req_ready), .op_valid(op_valid),
    .op_kind(op_kind), .dest_reg_field(dest_reg_field),
    .src_reg_field(src_reg_field), .pair_sel(pair_sel),
    .op_cycles(op_cycles), .op_done(op_done), .pass_valid(pass_valid),
    .pass_opcode(pass_opcode)
  );
  exec_req_model px_u (
    .clk(clk), .req_ready(req_ready), .opcode_valid(opcode_valid),
    .opcode(opcode)
  );

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // -------------------------------------------------------------
  // checking helpers
  // -------------------------------------------------------------
  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc >= 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // expected kind and count; count 0 means passed on
  function automatic void exp_of(input logic [7:0] op,
                                 output dec_pkg::op_kind_t k,
                                 output logic [4:0] c);
    k = dec_pkg::OP_NONE;
    c = 5'h00;
    if (op[7:6] == 2'h1 && op != 8'h76) begin
      if (op[5:3] == 3'h6) begin
        k = dec_pkg::OP_STORE_M;
        c = 5'h07;
      end else if (op[2:0] == 3'h6) begin
        k = dec_pkg::OP_LOAD_M;
        c = 5'h07;
      end else begin
        k = dec_pkg::OP_COPY;
        c = 5'h04;
      end
    end else begin
      case (op)
        8'h01, 8'h11, 8'h21: begin
          k = dec_pkg::OP_LOAD_PAIR_IMM;
          c = 5'h0a;
        end
        8'h31: begin
          k = dec_pkg::OP_LOAD_SP_IMM;
          c = 5'h0a;
        end
        8'heb: begin
          k = dec_pkg::OP_SWAP;
          c = 5'h04;
        end
        8'hc5, 8'hd5, 8'he5: begin
          k = dec_pkg::OP_PUSH_PAIR;
          c = 5'h0c;
        end
        8'hf5: begin
          k = dec_pkg::OP_PUSH_AF;
          c = 5'h0c;
        end
        8'hc1, 8'hd1, 8'he1: begin
          k = dec_pkg::OP_POP_PAIR;
          c = 5'h0a;
        end
        8'hf1: begin
          k = dec_pkg::OP_POP_AF;
          c = 5'h0a;
        end
        default: c = 5'h00;
      endcase
    end
  endfunction

  task automatic check_op(input logic [7:0] op);
    dec_pkg::op_kind_t k;
    logic [4:0]        c;
    exp_of(op, k, c);
    px_u.send(op, 1'b0);
    if (c == 5'h00) begin
      chk(8'(pass_valid), 8'h01);
      chk(8'(op_valid), 8'h00);
      chk(pass_opcode, op);
      // one idle edge so the strobe is not lowered and raised in one step
      @(posedge clk);
      #1;
    end else begin
      chk(8'(op_valid), 8'h01);
      chk(8'(op_kind), 8'(k));
      chk(8'(dest_reg_field), 8'(op[5:3]));
      chk(8'(src_reg_field), 8'(op[2:0]));
      chk(8'(pair_sel), 8'(op[5:4]));
      chk(8'(op_cycles), 8'(c));
      for (int i = 1; i < int'(c); i++) begin
        chk(8'(req_ready), 8'h00);
        chk(8'(op_done), 8'h00);
        @(posedge clk);
        #1;
      end
      chk(8'(req_ready), 8'h01);
      chk(8'(op_done), 8'h01);
    end
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    chk(8'(req_ready), 8'h01);
    chk(8'(op_valid), 8'h00);
    chk(8'(op_kind), 8'(dec_pkg::OP_NONE));
    chk(8'(op_cycles), 8'h00);
    chk(8'(pass_valid), 8'h00);
    chk(8'(op_done), 8'h00);
  endtask

  task automatic t_move_group();
    for (int i = 8'h40; i <= 8'h7f; i++)
      check_op(8'(i));
  endtask

  task automatic t_pair_and_stack();
    logic [7:0] ops [14] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'heb, 8'hc5,
      8'hd5, 8'he5, 8'hf5, 8'hc1, 8'hd1, 8'he1, 8'hf1, 8'h02};
    for (int i = 0; i < 5; i++)
      check_op(ops[i]);
    for (int i = 5; i < 14; i++)
      check_op(ops[i]);
  endtask

  // a request held high through a push is not taken early
  task automatic t_refuse_while_busy();
    px_u.send(8'hc5, 1'b1);
    chk(8'(op_valid), 8'h01);
    px_u.retarget(8'h3e);
    for (int i = 1; i < 12; i++) begin
      chk(8'(req_ready), 8'h00);
      chk(8'(pass_valid), 8'h00);
      @(posedge clk);
      #1;
    end
    chk(8'(op_done), 8'h01);
    // strobe stays up so the next scenario only changes the byte
    px_u.send(8'h3e, 1'b1);
    chk(8'(pass_valid), 8'h01);
    chk(pass_opcode, 8'h3e);
  endtask

  task automatic t_pass_back_to_back();
    logic [7:0] ops [4] = '{8'h06, 8'hc3, 8'he3, 8'h0a};
    foreach (ops[i]) begin
      px_u.send(ops[i], i < 3);
      chk(8'(pass_valid), 8'h01);
      chk(pass_opcode, ops[i]);
      chk(8'(op_valid), 8'h00);
    end
  endtask

  initial begin
    miscompares     = 0;
    samples_checked = 0;
    sys_rst         = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_move_group();
    t_pair_and_stack();
    t_refuse_while_busy();
    t_pass_back_to_back();
    give_verdict();
  end
endmodule
